// *** gpio_mux_consts.vh ***
// offsets, field codes, reset values and timing counts of the multiplexed port block
// assumes a 32-bit apb bus with byte addresses and a 25 mhz pclk
`ifndef GPIO_MUX_CONSTS_VH
`define GPIO_MUX_CONSTS_VH
`define ADDR_PORT_A_SEL 32'h01D20000
`define ADDR_PORT_A_VAL 32'h01D20004
`define ADDR_PORT_F_SEL 32'h01D20034
`define ADDR_PORT_F_VAL 32'h01D20038
`define ADDR_PORT_F_PUD 32'h01D2003C
`define ADDR_PORT_G_SEL 32'h01D20040
`define ADDR_PORT_G_VAL 32'h01D20044
`define ADDR_PORT_G_PUD 32'h01D20048
`define ADDR_EXT_TRIG 32'h01D2004C
`define ADDR_IRQ_STATUS 32'h01D20050
`define ADDR_IRQ_MASK 32'h01D20054
`define ADDR_PORT_E8_CTRL 32'h01D20058
`define ADDR_STRAP 32'h01D2005C
`define RST_PORT_A_SEL 10'h3FF
`define RST_PORT_A_VAL 10'h000
`define RST_PORT_F_SEL 4'h0
`define RST_PORT_G_SEL 16'h0000
`define RST_PUD_F 2'h0
`define RST_PUD_G 8'h00
`define RST_EXT_TRIG 24'h000000
`define RST_PORT_E8_CTRL 3'h0
// two-bit selector codes for ports f, g and pin e8
`define SEL_INPUT 2'h0
`define SEL_OUTPUT 2'h1
`define SEL_ALT 2'h2
`define SEL_EXT_IRQ 2'h3
`define E8_STRAP 2'h0
`define E8_CODEC_CLK 2'h1
`define E8_INPUT 2'h2
`define E8_OUTPUT 2'h3
// trigger types, three bits per channel
`define TRIG_LOW 3'h0
`define TRIG_HIGH 3'h1
`define TRIG_FALL 3'h2
`define TRIG_RISE 3'h4
`define TRIG_BOTH 3'h6
// a request must last longer than this many clocks
`define FILTER_CLOCKS 3
`define FILTER_STABLE (`FILTER_CLOCKS + 1)
// last count of a differing pin before the filtered level moves
`define FILTER_LAST 3'h3
`endif

// *** ext_irq_filter.v ***
// one external interrupt channel: glitch filter and trigger detection
// assumes the pin is synchronous to pclk
`timescale 1ns/100ps
`include "gpio_mux_consts.vh"
module ext_irq_filter (
  input wire pclk,
  input wire presetn,
  input wire enable,
  input wire pin_level,
  input wire [2:0] trigger,
  output reg request
);
  reg filtered;
  reg prev;
  reg [2:0] stable_count;
  wire fall = prev & ~filtered;
  wire rise = ~prev & filtered;

  // level only moves after the pin has held its new value long enough
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filtered <= 1'b1;
      prev <= 1'b1;
      stable_count <= 3'h0;
    end else begin
      prev <= filtered;
      if (pin_level == filtered) begin
        stable_count <= 3'h0;
      end else if (stable_count == `FILTER_LAST) begin
        filtered <= pin_level;
        stable_count <= 3'h0;
      end else begin
        stable_count <= stable_count + 3'h1;
      end
    end
  end

  always @* begin
    case (trigger)
      `TRIG_LOW: request = enable & ~filtered;
      `TRIG_HIGH: request = enable & filtered;
      `TRIG_FALL, 3'h3: request = enable & fall;
      `TRIG_RISE, 3'h5: request = enable & rise;
      `TRIG_BOTH, 3'h7: request = enable & (fall | rise);
      default: request = 1'b0;
    endcase
  end
endmodule

// *** gpio_mux_port.v ***
// multiplexed i/o port: function selectors, data and pull-up registers,
// open-drain two-wire pins, byte-order strap and eight filtered external interrupts
// assumes pins and peripheral signals are synchronous to pclk; apb slave, zero wait states
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "gpio_mux_consts.vh"
module gpio_mux_port (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output wire irq,
  input wire [9:0] addr_bus_out,
  output wire [9:0] port_a_pin_out,
  output wire [9:0] port_a_pin_oe,
  input wire [1:0] port_f_low_pins_in,
  output wire [1:0] port_f_low_pins_out,
  output wire [1:0] port_f_low_pins_oe,
  output wire [1:0] port_f_low_pullup_en,
  input wire [1:0] two_wire_drive_low,
  output wire [1:0] two_wire_level,
  input wire [7:0] port_g_pins_in,
  output wire [7:0] port_g_pins_out,
  output wire [7:0] port_g_pins_oe,
  output wire [7:0] port_g_pullup_en,
  input wire [7:0] port_g_alt_out,
  input wire [7:0] port_g_alt_oe,
  output wire [7:0] port_g_alt_in,
  input wire port_e_pin8_in,
  output wire port_e_pin8_out,
  output wire port_e_pin8_oe,
  input wire codec_clk,
  output reg big_endian
);
  reg [9:0] port_a_function_select;
  reg [9:0] port_a_output_value;
  reg [3:0] port_f_sel;
  reg [1:0] port_f_val;
  reg [1:0] port_f_pud;
  reg [15:0] port_g_sel;
  reg [7:0] port_g_val;
  reg [7:0] port_g_pud;
  reg [23:0] ext_irq_trigger_config;
  reg [7:0] irq_status;
  reg [7:0] irq_mask;
  reg [2:0] port_e8_ctrl;
  reg strap_done;
  reg [31:0] next_prdata;
  reg next_slverr;
  wire [7:0] irq_request;
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;

  function [1:0] sel2;
    input [15:0] sel;
    input [2:0] idx;
    begin
      sel2 = sel[{idx, 1'b0} +: 2];
    end
  endfunction

  // read-back of one port pin; function pins read the undefined case as zero
  function pin_read;
    input [1:0] sel;
    input pin;
    input val;
    begin
      case (sel)
        `SEL_INPUT: pin_read = pin;
        `SEL_OUTPUT: pin_read = val;
        default: pin_read = 1'b0;
      endcase
    end
  endfunction

  function map_hit;
    input [31:0] addr;
    begin
      case (addr)
        `ADDR_PORT_A_SEL, `ADDR_PORT_A_VAL, `ADDR_PORT_F_SEL, `ADDR_PORT_F_VAL,
        `ADDR_PORT_F_PUD, `ADDR_PORT_G_SEL, `ADDR_PORT_G_VAL, `ADDR_PORT_G_PUD,
        `ADDR_EXT_TRIG, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK, `ADDR_PORT_E8_CTRL,
        `ADDR_STRAP: map_hit = 1'b1;
        default: map_hit = 1'b0;
      endcase
    end
  endfunction

  // port a: output only, selector bit picks the address bus
  assign port_a_pin_out = (port_a_function_select & addr_bus_out) |
    (~port_a_function_select & port_a_output_value);
  assign port_a_pin_oe = 10'h3FF;

  // port f low pins are open drain in every mode
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : gen_f
      wire [1:0] mode = port_f_sel[2 * i +: 2];
      assign port_f_low_pins_out[i] = 1'b0;
      assign port_f_low_pins_oe[i] = (mode == `SEL_OUTPUT) ? ~port_f_val[i] :
        (mode == `SEL_ALT) ? two_wire_drive_low[i] : 1'b0;
      assign two_wire_level[i] = (mode == `SEL_ALT) ? port_f_low_pins_in[i] : 1'b1;
      assign port_f_low_pullup_en[i] = ~port_f_pud[i];
    end
    for (i = 0; i < 8; i = i + 1) begin : gen_g
      localparam [2:0] pin_idx = i;
      wire [1:0] mode = sel2(port_g_sel, pin_idx);
      assign port_g_pins_out[i] = (mode == `SEL_ALT) ? port_g_alt_out[i] : port_g_val[i];
      assign port_g_pins_oe[i] = (mode == `SEL_OUTPUT) | ((mode == `SEL_ALT) & port_g_alt_oe[i]);
      // idle peripherals see a released line, not a stale pin
      assign port_g_alt_in[i] = (mode == `SEL_ALT) ? port_g_pins_in[i] : 1'b1;
      assign port_g_pullup_en[i] = ~port_g_pud[i];
      // interrupts only work once software picks interrupt mode
      ext_irq_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .enable(mode == `SEL_EXT_IRQ),
        .pin_level(port_g_pins_in[i]),
        .trigger(ext_irq_trigger_config[3 * i +: 3]),
        .request(irq_request[i])
      );
    end
  endgenerate

  // pin e8: strap while in reset, then codec clock or plain i/o
  assign port_e_pin8_out = (port_e8_ctrl[1:0] == `E8_CODEC_CLK) ? codec_clk : port_e8_ctrl[2];
  assign port_e_pin8_oe = (port_e8_ctrl[1:0] == `E8_CODEC_CLK) |
    (port_e8_ctrl[1:0] == `E8_OUTPUT);

  // strap sampled on the first edge after release, never later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done <= 1'b0;
      big_endian <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      big_endian <= port_e_pin8_in;
    end
  end

  assign irq = |(irq_status & irq_mask);
  assign pready = psel & penable;

  // one strobe per register except the read-only strap; unmapped writes match none and are dropped
  wire we_a_sel = wr & (paddr == `ADDR_PORT_A_SEL);
  wire we_a_val = wr & (paddr == `ADDR_PORT_A_VAL);
  wire we_f_sel = wr & (paddr == `ADDR_PORT_F_SEL);
  wire we_f_val = wr & (paddr == `ADDR_PORT_F_VAL);
  wire we_f_pud = wr & (paddr == `ADDR_PORT_F_PUD);
  wire we_g_sel = wr & (paddr == `ADDR_PORT_G_SEL);
  wire we_g_val = wr & (paddr == `ADDR_PORT_G_VAL);
  wire we_g_pud = wr & (paddr == `ADDR_PORT_G_PUD);
  wire we_trig = wr & (paddr == `ADDR_EXT_TRIG);
  wire we_status = wr & (paddr == `ADDR_IRQ_STATUS);
  wire we_mask = wr & (paddr == `ADDR_IRQ_MASK);
  wire we_e8 = wr & (paddr == `ADDR_PORT_E8_CTRL);

  // registers; data registers have no meaningful reset, zero keeps sim clean
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_function_select <= `RST_PORT_A_SEL;
    end else if (we_a_sel) begin
      port_a_function_select <= pwdata[9:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_output_value <= `RST_PORT_A_VAL;
    end else if (we_a_val) begin
      port_a_output_value <= pwdata[9:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_f_sel <= `RST_PORT_F_SEL;
    end else if (we_f_sel) begin
      port_f_sel <= pwdata[3:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_f_val <= 2'h0;
    end else if (we_f_val) begin
      port_f_val <= pwdata[1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_f_pud <= `RST_PUD_F;
    end else if (we_f_pud) begin
      port_f_pud <= pwdata[1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_g_sel <= `RST_PORT_G_SEL;
    end else if (we_g_sel) begin
      port_g_sel <= pwdata[15:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_g_val <= 8'h00;
    end else if (we_g_val) begin
      port_g_val <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_g_pud <= `RST_PUD_G;
    end else if (we_g_pud) begin
      port_g_pud <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_trigger_config <= `RST_EXT_TRIG;
    end else if (we_trig) begin
      ext_irq_trigger_config <= pwdata[23:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= 8'h00;
    end else if (we_mask) begin
      irq_mask <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_e8_ctrl <= `RST_PORT_E8_CTRL;
    end else if (we_e8) begin
      port_e8_ctrl <= pwdata[2:0];
    end
  end

  // sticky status, write one to clear; a new request wins over the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 8'h00;
    end else if (we_status) begin
      irq_status <= (irq_status & ~pwdata[7:0]) | irq_request;
    end else begin
      irq_status <= irq_status | irq_request;
    end
  end

  // read mux; pins on peripheral functions read zero, the undefined case
  integer k;
  always @* begin
    next_prdata = 32'h00000000;
    next_slverr = ~map_hit(paddr);
    case (paddr)
      `ADDR_PORT_A_SEL: next_prdata[9:0] = port_a_function_select;
      `ADDR_PORT_A_VAL: next_prdata[9:0] = port_a_output_value & ~port_a_function_select;
      `ADDR_PORT_F_SEL: next_prdata[3:0] = port_f_sel;
      `ADDR_PORT_F_VAL: begin
        for (k = 0; k < 2; k = k + 1) begin
          next_prdata[k] = pin_read(port_f_sel[2 * k +: 2], port_f_low_pins_in[k], port_f_val[k]);
        end
      end
      `ADDR_PORT_F_PUD: next_prdata[1:0] = port_f_pud;
      `ADDR_PORT_G_SEL: next_prdata[15:0] = port_g_sel;
      `ADDR_PORT_G_VAL: begin
        for (k = 0; k < 8; k = k + 1) begin
          next_prdata[k] = pin_read(sel2(port_g_sel, k[2:0]), port_g_pins_in[k], port_g_val[k]);
        end
      end
      `ADDR_PORT_G_PUD: next_prdata[7:0] = port_g_pud;
      `ADDR_EXT_TRIG: next_prdata[23:0] = ext_irq_trigger_config;
      `ADDR_IRQ_STATUS: next_prdata[7:0] = irq_status;
      `ADDR_IRQ_MASK: next_prdata[7:0] = irq_mask;
      `ADDR_PORT_E8_CTRL: next_prdata[2:0] = (port_e8_ctrl[1:0] == `E8_INPUT) ?
        {port_e_pin8_in, port_e8_ctrl[1:0]} : port_e8_ctrl;
      `ADDR_STRAP: next_prdata[0] = big_endian;
      default: next_prdata = 32'h00000000;
    endcase
  end

  // read data and error captured in the setup cycle, stable through access
  // capturing early costs a flop stage but keeps prdata free of pin glitches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= next_slverr;
    end
  end
endmodule

// *** gpio_mux_port_sva.sv ***
// checker on the port block's pins and apb answer
// bound into gpio_mux_port; single pclk domain
`timescale 1ns/100ps
module gpio_mux_port_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire [9:0] addr_bus_out,
  input wire [9:0] port_a_pin_out,
  input wire [9:0] port_a_pin_oe,
  input wire [1:0] port_f_low_pins_out,
  input wire [1:0] port_f_low_pullup_en,
  input wire [7:0] port_g_pins_oe,
  input wire [7:0] port_g_pullup_en,
  input wire [7:0] port_g_alt_oe,
  input wire [7:0] port_g_alt_in,
  input wire port_e_pin8_in,
  input wire port_e_pin8_oe,
  input wire big_endian
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_drive_a: assert property (port_a_pin_oe == 10'h3FF) else $error("port a oe");
  f_drain_a: assert property (port_f_low_pins_out == 2'h0) else $error("open drain high");
  rst_func_a: assert property ($rose(presetn) |-> port_a_pin_out == addr_bus_out
    && port_g_pins_oe == 8'h00 && !port_e_pin8_oe) else $error("reset function");
  rst_pullup_a: assert property ($rose(presetn) |-> port_f_low_pullup_en == 2'h3
    && port_g_pullup_en == 8'hFF) else $error("reset pullup");
  strap_hold_a: assert property ($rose(presetn) |=> big_endian == $past(port_e_pin8_in)
    ##1 $stable(big_endian)[*8]) else $error("strap");
  alt_route_a: assert property ((~port_g_alt_in & (port_g_pins_oe ^ port_g_alt_oe)) == 8'h00)
    else $error("alt oe");
  refuse_zero_a: assert property (psel && penable && pslverr |-> prdata == 32'h0)
    else $error("refused data");
  a_pin_hold_a: assert property (!$past(psel && penable && pwrite) && $stable(addr_bus_out)
    |-> $stable(port_a_pin_out)) else $error("port a moved");
endmodule
bind gpio_mux_port gpio_mux_port_sva chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pslverr,
  .addr_bus_out, .port_a_pin_out, .port_a_pin_oe, .port_f_low_pins_out, .port_f_low_pullup_en,
  .port_g_pins_oe, .port_g_pullup_en, .port_g_alt_oe, .port_g_alt_in, .port_e_pin8_in, .port_e_pin8_oe,
  .big_endian);

// *** board_model.sv ***
// board around the port pins
// assumes the bench sets what the board drives
`timescale 1ns/100ps
module board_model (
  input wire [7:0] g_out,
  input wire [7:0] g_oe,
  input wire [7:0] g_ext,
  input wire [1:0] f_oe,
  input wire [1:0] f_low,
  input wire e8_out,
  input wire e8_oe,
  input wire e8_ext,
  output wire [7:0] g_in,
  output wire [1:0] f_in,
  output wire e8_in
);
  assign g_in = (g_oe & g_out) | (~g_oe & g_ext);
  // board resistors hold released lines high
  assign f_in = ~f_oe | f_low;
  assign e8_in = e8_oe ? e8_out : e8_ext;
endmodule

// *** testbench.sv ***
// self-checking bench for the multiplexed port block
// board_model closes the pins; checker binds itself
`timescale 1ns/100ps
`include "gpio_mux_consts.vh"
module testbench;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e8_ext = 0, codec_clk = 0;
  reg [31:0] paddr = 0, pwdata = 0, r, s;
  reg [9:0] addr_bus_out = 0;
  reg [7:0] alt_out = 0, alt_oe = 0, g_ext = 8'hFF;
  reg [1:0] tw_low = 0;
  reg [32:0] q[$];
  reg [32:0] m;
  wire pready, pslverr, irq, e8_out, e8_oe, e8_in;
  wire [31:0] prdata;
  wire [9:0] a_out, a_oe;
  wire [1:0] f_in, f_oe, f_pu, tw_lvl, f_low;
  wire [7:0] g_in, g_out, g_oe, g_pu, alt_in;
  integer fails = 0, tests_run = 0, cyc = 0, i, c;
  gpio_mux_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .irq, .addr_bus_out, .port_a_pin_out(a_out), .port_a_pin_oe(a_oe), .port_f_low_pins_in(f_in),
    .port_f_low_pins_out(f_low), .port_f_low_pins_oe(f_oe), .port_f_low_pullup_en(f_pu),
    .two_wire_drive_low(tw_low), .two_wire_level(tw_lvl), .port_g_pins_in(g_in), .port_g_pins_out(g_out),
    .port_g_pins_oe(g_oe), .port_g_pullup_en(g_pu), .port_g_alt_out(alt_out), .port_g_alt_oe(alt_oe),
    .port_g_alt_in(alt_in), .port_e_pin8_in(e8_in), .port_e_pin8_out(e8_out), .port_e_pin8_oe(e8_oe),
    .codec_clk, .big_endian());
  board_model board (.g_out, .g_oe, .g_ext, .f_oe, .f_low, .e8_out, .e8_oe, .e8_ext, .g_in, .f_in, .e8_in);
  always #20 pclk = ~pclk;
  task automatic chk(input [31:0] got, exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // request held until pready is sampled high
  task apb(input w, input [31:0] a, d, input [32:0] e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    q.push_back(e);
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input [31:0] a, d);
    apb(1, a, d, 0);
  endtask
  task rd(input [31:0] a, e);
    apb(0, a, 0, {1'b0, e});
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      results;
    end
    if (psel && penable && pready === 1'b1) begin
      m = q.pop_front();
      chk(pslverr, m[32]);
      if (!pwrite) chk(prdata, m[31:0]);
    end
  end
  initial begin
    void'($urandom(32'hB660FA69));
    s = $urandom;
    e8_ext = s[0];
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rd(`ADDR_STRAP, s[0]);
    e8_ext <= ~s[0];
    rd(`ADDR_STRAP, s[0]);
    rd(`ADDR_PORT_A_SEL, 32'h3FF);
    rd(`ADDR_PORT_G_SEL, 0);
    rd(`ADDR_EXT_TRIG, 0);
    apb(0, 32'h01D20008, 0, 33'h100000000);
    s = $urandom;
    r = $urandom;
    addr_bus_out <= s[31:22];
    wr(`ADDR_PORT_A_VAL, s);
    wr(`ADDR_PORT_A_SEL, r);
    @(negedge pclk);
    chk(a_out, (s[9:0] & ~r[9:0]) | (addr_bus_out & r[9:0]));
    rd(`ADDR_PORT_A_SEL, r[9:0]);
    rd(`ADDR_PORT_A_VAL, s[9:0] & ~r[9:0]);
    g_ext <= s[7:0];
    rd(`ADDR_PORT_G_VAL, s[7:0]);
    wr(`ADDR_PORT_G_SEL, 32'h5555);
    wr(`ADDR_PORT_G_VAL, r);
    @(negedge pclk);
    chk({g_oe, g_out}, {8'hFF, r[7:0]});
    alt_out <= r[31:24];
    alt_oe <= s[23:16];
    wr(`ADDR_PORT_G_SEL, 32'hAAAA);
    rd(`ADDR_PORT_G_VAL, 0);
    chk(alt_in, (alt_oe & alt_out) | (~alt_oe & g_ext));
    chk(g_oe, alt_oe);
    wr(`ADDR_PORT_G_PUD, r);
    wr(`ADDR_PORT_F_PUD, r);
    @(negedge pclk);
    chk({f_pu, g_pu}, {2'h3 ^ r[1:0], 8'hFF ^ r[7:0]});
    wr(`ADDR_PORT_F_SEL, 32'h5);
    wr(`ADDR_PORT_F_VAL, 32'h2);
    @(negedge pclk);
    chk({f_oe, f_in}, 4'h6);
    tw_low <= s[1:0];
    wr(`ADDR_PORT_F_SEL, 32'hA);
    @(negedge pclk);
    chk({f_oe, tw_lvl}, {s[1:0], 2'h3 ^ s[1:0]});
    wr(`ADDR_PORT_E8_CTRL, 32'h7);
    @(negedge pclk);
    chk({e8_oe, e8_out}, 2'h3);
    codec_clk <= 1;
    wr(`ADDR_PORT_E8_CTRL, 32'h1);
    @(negedge pclk);
    chk({e8_oe, e8_out}, 2'h3);
    wr(`ADDR_PORT_E8_CTRL, 32'h2);
    rd(`ADDR_PORT_E8_CTRL, {29'h0, e8_ext, 2'h2});
    g_ext <= 8'hFF;
    wr(`ADDR_PORT_G_SEL, 32'hFFFF);
    for (i = 0; i < 5; i = i + 1) begin
      c = (i < 2) ? i : 2 * (i - 1);
      wr(`ADDR_IRQ_MASK, 32'hFF);
      wr(`ADDR_EXT_TRIG, c);
      wr(`ADDR_IRQ_STATUS, 32'hFF);
      // three low clocks is one short of a request
      g_ext[0] <= 0;
      repeat (3) @(posedge pclk);
      g_ext[0] <= 1;
      repeat (8) @(posedge pclk);
      rd(`ADDR_IRQ_STATUS, c == 1);
      g_ext[0] <= 0;
      repeat (8) @(posedge pclk);
      rd(`ADDR_IRQ_STATUS, c != 4);
      chk(irq, c != 4);
      wr(`ADDR_IRQ_STATUS, 32'hFF);
      g_ext[0] <= 1;
      repeat (8) @(posedge pclk);
      rd(`ADDR_IRQ_STATUS, c != 2);
      wr(`ADDR_IRQ_MASK, 0);
      @(negedge pclk);
      chk(irq, 0);
    end
    e8_ext <= 1;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(`ADDR_STRAP, 1);
    rd(`ADDR_PORT_A_SEL, 32'h3FF);
    results;
  end
endmodule
